// ==== ppsrv_pkg.sv ====
// Constants shared by the PIPE status, reset and verifier logic.
// Assumes a single 100 MHz parallel clock and a plain register port.
package ppsrv_pkg;

  // Clock and timing
  localparam int CLK_MHZ = 100;
  localparam int PD_ACK_NS = 40;
  localparam int PD_ACK_CYC = (PD_ACK_NS * CLK_MHZ + 999) / 1000;
  localparam int CAL_STEPS = 16;
  localparam int ERR_HOLD = 3;
  localparam int PRBS_LEN = 127;
  localparam int PRBS_TAP_A = 7;
  localparam int PRBS_TAP_B = 6;

  // Register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_RXWORD = 8'h08;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // Control fields
  localparam int CTRL_INFER_EN = 0;
  localparam int CTRL_PRBS = 1;
  localparam int CTRL_VER_EN = 2;
  localparam int CTRL_CAL_PD = 3;
  localparam int CTRL_VER_CLR = 4;

  // Status fields
  localparam int STAT_VER_ERR = 0;
  localparam int STAT_VER_DONE = 1;
  localparam int STAT_CAL_DONE = 2;
  localparam int STAT_IDLE = 3;
  localparam int STAT_PD = 4;
  localparam int STAT_RXST = 8;

  // Receiver status codes
  localparam logic [2:0] RXST_OK = 3'h0;
  localparam logic [2:0] RXST_SKP_ADD = 3'h1;
  localparam logic [2:0] RXST_SKP_REM = 3'h2;
  localparam logic [2:0] RXST_DETECTED = 3'h3;
  localparam logic [2:0] RXST_DEC_ERR = 3'h4;
  localparam logic [2:0] RXST_EB_OVF = 3'h5;
  localparam logic [2:0] RXST_EB_UNF = 3'h6;
  localparam logic [2:0] RXST_DISP_ERR = 3'h7;

  // Power states
  localparam logic [1:0] PS_P1 = 2'h2;

  // Asynchronous input positions in the synchroniser bank
  localparam int SY_SIGDET = 0;
  localparam int SY_PWRDN = 1;
  localparam int SY_RXA_RST = 2;
  localparam int SY_RXD_RST = 3;
  localparam int SY_TXD_RST = 4;
  localparam int SY_DET_DONE = 5;
  localparam int SY_DET_HIT = 6;
  localparam int SY_CAL_CLK = 7;
  localparam int SY_N = 8;

  typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_DONE} ppsrv_cal_t;

endpackage : ppsrv_pkg

// ==== ppsrv_ver_if.sv ====
// Bundle between the top and the pattern verifier.
// Assumes both ends run on the parallel clock.
`timescale 1ns/1ps
`default_nettype none
interface ppsrv_ver_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic valid;
  logic prbs_mode;
  logic enable;
  logic clear;
  logic err;
  logic done;
  modport ctl (output data, output valid, output prbs_mode, output enable, output clear, input err, input done);
  modport verifier (input data, input valid, input prbs_mode, input enable, input clear, output err, output done);
endinterface : ppsrv_ver_if
`default_nettype wire

// ==== ppsrv_verifier.sv ====
// Incrementing-pattern and PRBS7 verifier on received words.
// Assumes words arrive with a valid strobe on the parallel clock; W >= 7.
`timescale 1ns/1ps
`default_nettype none
module ppsrv_verifier #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  ppsrv_ver_if.verifier vif
);

  localparam int CW = W + 1;
  localparam logic [CW-1:0] BIST_LAST = CW'((1 << W) - 1);
  localparam logic [CW-1:0] PRBS_LAST = CW'(ppsrv_pkg::PRBS_LEN);
  localparam logic [1:0] HOLD_INIT = 2'(ppsrv_pkg::ERR_HOLD - 1);

  // Self-synchronising: the next word is predicted from the last one
  function automatic logic [W-1:0] prbs_next(input logic [W-1:0] p);
    logic [W-1:0] w;
    logic nb;
    w = p;
    for (int i = 0; i < W; i++) begin
      nb = w[W - ppsrv_pkg::PRBS_TAP_A] ^ w[W - ppsrv_pkg::PRBS_TAP_B];
      w = {nb, w[W-1:1]};
    end
    return w;
  endfunction : prbs_next

  logic locked_r, locked_nxt;
  logic [W-1:0] prev_r, prev_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic err_r, err_nxt;
  logic done_r, done_nxt;
  logic [1:0] hold_r, hold_nxt;
  logic [W-1:0] expect_w;
  logic miss;

  always_comb begin
    expect_w = vif.prbs_mode ? prbs_next(prev_r) : W'(prev_r + 1'b1);
    miss = vif.valid && locked_r && (vif.data != expect_w);
    locked_nxt = locked_r;
    prev_nxt = prev_r;
    cnt_nxt = cnt_r;
    err_nxt = err_r;
    done_nxt = done_r;
    hold_nxt = (hold_r != 2'h0) ? hold_r - 2'h1 : hold_r;
    if (!vif.enable || vif.clear) begin
      locked_nxt = 1'b0;
      cnt_nxt = '0;
      err_nxt = 1'b0;
      done_nxt = 1'b0;
      hold_nxt = 2'h0;
    end else if (vif.valid) begin
      locked_nxt = 1'b1;
      prev_nxt = vif.data;
      if (locked_r && !done_r) begin
        cnt_nxt = cnt_r + CW'(1);
      end
      if (!vif.prbs_mode) begin
        if (miss) begin
          err_nxt = 1'b1;
          done_nxt = 1'b1;
        end
        if (locked_r && cnt_r == BIST_LAST - CW'(1)) begin
          done_nxt = 1'b1;
        end
      end else begin
        if (miss) begin
          err_nxt = 1'b1;
          hold_nxt = HOLD_INIT;
        end else if (locked_r && hold_r == 2'h0) begin
          err_nxt = 1'b0;
        end
        if (locked_r && cnt_r == PRBS_LAST - CW'(1)) begin
          done_nxt = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      locked_r <= 1'b0;
      prev_r <= '0;
      cnt_r <= '0;
      err_r <= 1'b0;
      done_r <= 1'b0;
      hold_r <= 2'h0;
    end else begin
      locked_r <= locked_nxt;
      prev_r <= prev_nxt;
      cnt_r <= cnt_nxt;
      err_r <= err_nxt;
      done_r <= done_nxt;
      hold_r <= hold_nxt;
    end
  end

  assign vif.err = err_r;
  assign vif.done = done_r;

endmodule : ppsrv_verifier
`default_nettype wire

// ==== ppsrv_top.sv ====
// PIPE-side status, idle, reset and calibration control of one channel,
// with a register port and the pattern verifier.
// Assumes MAC-side inputs are on clk; analog and reset pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module ppsrv_top #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [ppsrv_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic force_idle,
  input wire logic [1:0] power_state,
  input wire logic det_loop_req,
  input wire logic infer_idle,
  input wire logic sig_detect,
  input wire logic det_done_pin,
  input wire logic det_hit_pin,
  input wire logic [W-1:0] rx_word_in,
  input wire logic [W/8-1:0] rx_ctl_in,
  input wire logic rx_word_ok,
  input wire logic skip_added,
  input wire logic skip_removed,
  input wire logic decode_err,
  input wire logic ebuf_over,
  input wire logic ebuf_under,
  input wire logic disp_err,
  input wire logic block_pwrdn,
  input wire logic rx_analog_rst,
  input wire logic rx_digital_rst,
  input wire logic tx_digital_rst,
  input wire logic cal_clk,
  output logic tx_idle_r,
  output logic idle_ind_r,
  output logic phy_done_r,
  output logic [2:0] rx_status_r,
  output logic rx_valid_r,
  output logic [W-1:0] rx_word_r,
  output logic [W/8-1:0] rx_ctl_r,
  output logic rx_pma_rst_r,
  output logic rx_pcs_rst_r,
  output logic tx_pcs_rst_r,
  output logic block_off_r,
  output logic cal_run_r
);

  localparam logic [3:0] PD_ACK = 4'(ppsrv_pkg::PD_ACK_CYC);
  localparam logic [4:0] CAL_LAST = 5'(ppsrv_pkg::CAL_STEPS - 1);

  // Highest-severity event wins when several land on one word
  function automatic logic [2:0] rx_code(input logic [5:0] ev);
    logic [2:0] c;
    c = ppsrv_pkg::RXST_OK;
    if (ev[0]) c = ppsrv_pkg::RXST_SKP_ADD;
    if (ev[1]) c = ppsrv_pkg::RXST_SKP_REM;
    if (ev[3]) c = ppsrv_pkg::RXST_EB_UNF;
    if (ev[2]) c = ppsrv_pkg::RXST_EB_OVF;
    if (ev[5]) c = ppsrv_pkg::RXST_DISP_ERR;
    if (ev[4]) c = ppsrv_pkg::RXST_DEC_ERR;
    return c;
  endfunction : rx_code

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for pins from outside the clock domain

  logic [ppsrv_pkg::SY_N-1:0] sy_raw, sy_meta_r, sy_r;
  assign sy_raw = {cal_clk, det_hit_pin, det_done_pin, tx_digital_rst,
                   rx_digital_rst, rx_analog_rst, block_pwrdn, sig_detect};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sy_meta_r <= '0;
      sy_r <= '0;
    end else begin
      sy_meta_r <= sy_raw;
      sy_r <= sy_meta_r;
    end
  end

  logic pd_s;
  assign pd_s = sy_r[ppsrv_pkg::SY_PWRDN];

  ////////////////////////////////////////////////////////////////////////////
  // Register port

  logic [31:0] ctrl_r, ctrl_nxt;
  logic [31:0] rdata_nxt;
  logic ver_clr_r, ver_clr_nxt;
  ppsrv_pkg::ppsrv_cal_t cal_st_r, cal_st_nxt;
  ppsrv_ver_if #(.W(W)) vif ();

  always_comb begin
    ctrl_nxt = ctrl_r;
    ver_clr_nxt = 1'b0;
    rdata_nxt = '0;
    if (reg_wr && reg_addr == ppsrv_pkg::ADDR_CTRL) begin
      ctrl_nxt = {28'h0000000, reg_wdata[3:0]};
      ver_clr_nxt = reg_wdata[ppsrv_pkg::CTRL_VER_CLR];
    end
    if (reg_rd) begin
      unique case (reg_addr)
        ppsrv_pkg::ADDR_CTRL: rdata_nxt = ctrl_r;
        ppsrv_pkg::ADDR_STAT: begin
          rdata_nxt[ppsrv_pkg::STAT_VER_ERR] = vif.err;
          rdata_nxt[ppsrv_pkg::STAT_VER_DONE] = vif.done;
          rdata_nxt[ppsrv_pkg::STAT_CAL_DONE] = cal_st_r == ppsrv_pkg::CAL_DONE;
          rdata_nxt[ppsrv_pkg::STAT_IDLE] = idle_ind_r;
          rdata_nxt[ppsrv_pkg::STAT_PD] = block_off_r;
          rdata_nxt[ppsrv_pkg::STAT_RXST +: 3] = rx_status_r;
        end
        ppsrv_pkg::ADDR_RXWORD: rdata_nxt[W-1:0] = rx_word_r;
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r <= ppsrv_pkg::CTRL_RESET;
      ver_clr_r <= 1'b0;
      reg_rdata <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
      ver_clr_r <= ver_clr_nxt;
      reg_rdata <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-down and reset outputs

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      block_off_r <= 1'b1;
      rx_pma_rst_r <= 1'b1;
      rx_pcs_rst_r <= 1'b1;
      tx_pcs_rst_r <= 1'b1;
    end else begin
      block_off_r <= pd_s;
      rx_pma_rst_r <= pd_s | sy_r[ppsrv_pkg::SY_RXA_RST];
      rx_pcs_rst_r <= pd_s | sy_r[ppsrv_pkg::SY_RXD_RST];
      tx_pcs_rst_r <= pd_s | sy_r[ppsrv_pkg::SY_TXD_RST];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Electrical idle

  logic tx_idle_nxt, idle_ind_nxt;

  always_comb begin
    tx_idle_nxt = force_idle | pd_s;
    if (ctrl_r[ppsrv_pkg::CTRL_INFER_EN]) begin
      idle_ind_nxt = infer_idle;
    end else begin
      idle_ind_nxt = ~sy_r[ppsrv_pkg::SY_SIGDET];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_idle_r <= 1'b1;
      idle_ind_r <= 1'b1;
    end else begin
      tx_idle_r <= tx_idle_nxt;
      idle_ind_r <= idle_ind_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PHY completion and receive status

  logic [1:0] ps_r, ps_nxt;
  logic [3:0] ps_cnt_r, ps_cnt_nxt;
  logic det_busy_r, det_busy_nxt;
  logic det_seen_r, det_seen_nxt;
  logic phy_done_nxt;
  logic [2:0] rx_status_nxt;
  logic rx_valid_nxt;

  always_comb begin
    ps_nxt = power_state;
    ps_cnt_nxt = (ps_cnt_r != 4'h0) ? ps_cnt_r - 4'h1 : ps_cnt_r;
    det_busy_nxt = det_busy_r;
    det_seen_nxt = sy_r[ppsrv_pkg::SY_DET_DONE];
    phy_done_nxt = 1'b0;
    rx_status_nxt = rx_code({disp_err, decode_err, ebuf_under, ebuf_over, skip_removed, skip_added});
    rx_valid_nxt = rx_word_ok && !pd_s && !rx_pcs_rst_r;
    if (power_state != ps_r) begin
      ps_cnt_nxt = PD_ACK;
    end
    // Only in P1 with tx idle; a done pin still high means a stale request
    if (!det_busy_r && det_loop_req && force_idle && power_state == ppsrv_pkg::PS_P1 &&
        !sy_r[ppsrv_pkg::SY_DET_DONE]) begin
      det_busy_nxt = 1'b1;
    end
    if (det_busy_r && sy_r[ppsrv_pkg::SY_DET_DONE] && !det_seen_r) begin
      det_busy_nxt = 1'b0;
      phy_done_nxt = 1'b1;
      rx_status_nxt = sy_r[ppsrv_pkg::SY_DET_HIT] ? ppsrv_pkg::RXST_DETECTED : ppsrv_pkg::RXST_OK;
    end else if (ps_cnt_r == 4'h1) begin
      phy_done_nxt = 1'b1;
    end
    if (pd_s) begin
      phy_done_nxt = 1'b0;
      det_busy_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ps_r <= '0;
      ps_cnt_r <= '0;
      det_busy_r <= 1'b0;
      det_seen_r <= 1'b0;
      phy_done_r <= 1'b0;
      rx_status_r <= ppsrv_pkg::RXST_OK;
      rx_valid_r <= 1'b0;
      rx_word_r <= '0;
      rx_ctl_r <= '0;
    end else begin
      ps_r <= ps_nxt;
      ps_cnt_r <= ps_cnt_nxt;
      det_busy_r <= det_busy_nxt;
      det_seen_r <= det_seen_nxt;
      phy_done_r <= phy_done_nxt;
      rx_status_r <= rx_status_nxt;
      rx_valid_r <= rx_valid_nxt;
      rx_word_r <= rx_word_in;
      rx_ctl_r <= rx_ctl_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Calibration, stepped by rising edges of the calibration clock

  logic [4:0] cal_cnt_r, cal_cnt_nxt;
  logic cal_ck_r;
  logic cal_tick;
  logic cal_off;

  always_comb begin
    cal_tick = sy_r[ppsrv_pkg::SY_CAL_CLK] && !cal_ck_r;
    cal_off = ctrl_r[ppsrv_pkg::CTRL_CAL_PD] | pd_s;
    cal_st_nxt = cal_st_r;
    cal_cnt_nxt = cal_cnt_r;
    unique case (cal_st_r)
      ppsrv_pkg::CAL_IDLE: begin
        cal_cnt_nxt = '0;
        if (cal_tick) cal_st_nxt = ppsrv_pkg::CAL_RUN;
      end
      ppsrv_pkg::CAL_RUN: begin
        if (cal_tick) cal_cnt_nxt = cal_cnt_r + 5'h01;
        if (cal_tick && cal_cnt_r == CAL_LAST) cal_st_nxt = ppsrv_pkg::CAL_DONE;
      end
      ppsrv_pkg::CAL_DONE: cal_st_nxt = ppsrv_pkg::CAL_DONE;
    endcase
    if (cal_off) begin
      cal_st_nxt = ppsrv_pkg::CAL_IDLE;
      cal_cnt_nxt = '0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cal_st_r <= ppsrv_pkg::CAL_IDLE;
      cal_cnt_r <= '0;
      cal_ck_r <= 1'b0;
      cal_run_r <= 1'b0;
    end else begin
      cal_st_r <= cal_st_nxt;
      cal_cnt_r <= cal_cnt_nxt;
      cal_ck_r <= sy_r[ppsrv_pkg::SY_CAL_CLK];
      cal_run_r <= cal_st_nxt == ppsrv_pkg::CAL_RUN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Verifier

  assign vif.data = rx_word_r;
  assign vif.valid = rx_valid_r;
  assign vif.prbs_mode = ctrl_r[ppsrv_pkg::CTRL_PRBS];
  assign vif.enable = ctrl_r[ppsrv_pkg::CTRL_VER_EN] && !rx_pcs_rst_r;
  assign vif.clear = ver_clr_r;

  ppsrv_verifier #(.W(W)) u_ver (
    .clk(clk),
    .sys_rst(sys_rst),
    .vif(vif)
  );

endmodule : ppsrv_top
`default_nettype wire

// ==== ppsrv_props.sv ====
// Port-level checker of the PIPE status, reset and idle block.
// Assumes one clock domain; sys_rst asynchronous, active high.
`timescale 1ns/1ps
`default_nettype none
module ppsrv_props #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic force_idle,
  input wire logic det_loop_req,
  input wire logic [W-1:0] rx_word_in,
  input wire logic rx_word_ok,
  input wire logic decode_err,
  input wire logic block_pwrdn,
  input wire logic rx_analog_rst,
  input wire logic rx_digital_rst,
  input wire logic tx_digital_rst,
  input wire logic tx_idle_r,
  input wire logic phy_done_r,
  input wire logic [2:0] rx_status_r,
  input wire logic rx_valid_r,
  input wire logic [W-1:0] rx_word_r,
  input wire logic rx_pma_rst_r,
  input wire logic rx_pcs_rst_r,
  input wire logic tx_pcs_rst_r,
  input wire logic block_off_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  a_tx_idle_forced: assert property (force_idle |=> tx_idle_r)
    else $error("tx idle not forced");
  a_done_one_cycle: assert property (phy_done_r |=> !phy_done_r)
    else $error("completion longer than one cycle");
  a_valid_has_cause: assert property (rx_valid_r |-> $past(rx_word_ok))
    else $error("receive valid without a word");
  a_decode_err_code: assert property (rx_word_ok && decode_err && !det_loop_req && !rx_pcs_rst_r && !block_off_r
    |=> rx_status_r == ppsrv_pkg::RXST_DEC_ERR) else $error("decode error code wrong");
  a_word_in_step: assert property (rx_word_ok && !rx_pcs_rst_r |=> rx_word_r == $past(rx_word_in))
    else $error("word not in step");
  a_pma_rst_held: assert property (rx_analog_rst [*4] |-> rx_pma_rst_r)
    else $error("receiver analog reset not held");
  a_pcs_rst_held: assert property (rx_digital_rst [*5] |-> rx_pcs_rst_r && !rx_valid_r)
    else $error("receiver digital reset not held");
  a_tx_rst_held: assert property (tx_digital_rst [*4] |-> tx_pcs_rst_r)
    else $error("transmitter digital reset not held");
  a_pwrdn_all_off: assert property (block_pwrdn [*5] |-> block_off_r && tx_idle_r && !rx_valid_r && !phy_done_r)
    else $error("power-down not honoured");
  a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  c_detect_done: cover property (phy_done_r && rx_status_r == ppsrv_pkg::RXST_DETECTED);
  c_disp_word: cover property (rx_valid_r && rx_status_r == ppsrv_pkg::RXST_DISP_ERR);
  c_power_cycle: cover property (block_off_r ##1 !block_off_r);
endmodule : ppsrv_props
bind ppsrv_top ppsrv_props #(.W(W)) i_ppsrv_props (.clk, .sys_rst, .reg_rd, .reg_rdata, .force_idle,
  .det_loop_req, .rx_word_in, .rx_word_ok, .decode_err, .block_pwrdn, .rx_analog_rst, .rx_digital_rst,
  .tx_digital_rst, .tx_idle_r, .phy_done_r, .rx_status_r, .rx_valid_r, .rx_word_r, .rx_pma_rst_r,
  .rx_pcs_rst_r, .tx_pcs_rst_r, .block_off_r);
`default_nettype wire

// ==== ppsrv_mac_model.sv ====
// Link-layer side model: power state, force idle, detect request.
// Assumes the bench commands it on clk; slow drops the request late.
`timescale 1ns/1ps
`default_nettype none
module ppsrv_mac_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic phy_done_r,
  input wire logic [1:0] ps_cmd,
  input wire logic idle_cmd,
  input wire logic det_cmd,
  input wire logic slow,
  output logic force_idle,
  output logic [1:0] power_state,
  output logic det_loop_req
);
  logic drop_r;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      force_idle <= 1'b0;
      power_state <= 2'h0;
      det_loop_req <= 1'b0;
      drop_r <= 1'b0;
    end else begin
      force_idle <= idle_cmd;
      power_state <= ps_cmd;
      drop_r <= phy_done_r & slow;
      if ((phy_done_r & !slow) | drop_r)
        det_loop_req <= 1'b0;
      else if (det_cmd && force_idle && power_state == ppsrv_pkg::PS_P1)
        det_loop_req <= 1'b1;
    end
  end
endmodule : ppsrv_mac_model
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench of the PIPE status block with a link-layer model.
// Assumes the checker is bound to the top by its own file.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin errors++; $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module tb;
  localparam int W = 8;
  logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, infer_idle = 0, sig_detect = 0, cal_clk = 0;
  logic det_done_pin = 0, det_hit_pin = 0, rx_word_ok = 0, block_pwrdn = 0, idle_cmd = 0, det_cmd = 0;
  logic slow = 0, force_idle, det_loop_req, tx_idle_r, idle_ind_r, phy_done_r, rx_valid_r, rx_ctl_r;
  logic rx_pma_rst_r, rx_pcs_rst_r, tx_pcs_rst_r, block_off_r, cal_run_r;
  logic [1:0] ps_cmd = 2'h0, power_state;
  logic [2:0] rst_v = 3'h0, cdiv = 3'h0, rx_status_r;
  logic [5:0] ev = 6'h0;
  logic [6:0] lf = 7'h7f;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic [W-1:0] rx_word_in = '0, rx_word_r;
  int errors = 0, n_tests = 0;
  ppsrv_top #(.W(W)) i_ppsrv_top (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .force_idle, .power_state, .det_loop_req, .infer_idle, .sig_detect, .det_done_pin, .det_hit_pin,
    .rx_word_in, .rx_ctl_in(rx_word_in[0:0]), .rx_word_ok, .skip_added(ev[0]), .skip_removed(ev[1]),
    .decode_err(ev[2]), .ebuf_over(ev[3]), .ebuf_under(ev[4]), .disp_err(ev[5]), .block_pwrdn,
    .rx_analog_rst(rst_v[0]), .rx_digital_rst(rst_v[1]), .tx_digital_rst(rst_v[2]), .cal_clk, .tx_idle_r,
    .idle_ind_r, .phy_done_r, .rx_status_r, .rx_valid_r, .rx_word_r, .rx_ctl_r, .rx_pma_rst_r,
    .rx_pcs_rst_r, .tx_pcs_rst_r, .block_off_r, .cal_run_r);
  ppsrv_mac_model i_ppsrv_mac_model (.clk, .sys_rst, .phy_done_r, .ps_cmd, .idle_cmd, .det_cmd, .slow,
    .force_idle, .power_state, .det_loop_req);
  always #5 clk = ~clk;
  // Calibration clock at clk/8, well under the clk/4 limit
  always @(posedge clk) begin
    cdiv <= cdiv + 3'h1;
    cal_clk <= cdiv[2];
  end
  ////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic feed(input logic [W-1:0] w);
    @(posedge clk);
    rx_word_in <= w;
    rx_word_ok <= 1'b1;
  endtask : feed
  task automatic hush(input int n);
    @(posedge clk);
    rx_word_ok <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : hush
  // Next PRBS7 word, newest bit in the msb
  function automatic logic [W-1:0] pw();
    logic [W-1:0] w = '0;
    for (int b = 0; b < W; b++) begin
      lf = {lf[5:0], lf[6] ^ lf[5]};
      w = {lf[0], w[W-1:1]};
    end
    return w;
  endfunction : pw
  task automatic t_status;
    logic [2:0] code [7] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7, 3'h0};
    rd(8'h00);
    `CHK("ctrl reset", ppsrv_pkg::CTRL_RESET, d)
    wr(8'h0c, 32'h0000_00ff);
    rd(8'h0c);
    `CHK("unmapped", 32'h0, d)
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      ev <= 6'(1 << i);
      rx_word_in <= W'(8'h30 + i);
      rx_word_ok <= 1'b1;
      @(posedge clk);
      ev <= 6'h0;
      rx_word_ok <= 1'b0;
      #1 `CHK("status", code[i], rx_status_r)
      `CHK("valid", 1'b1, rx_valid_r)
      `CHK("word", W'(8'h30 + i), rx_word_r)
      `CHK("ctl bits", i[0], rx_ctl_r)
      @(posedge clk);
      #1 `CHK("valid off", 1'b0, rx_valid_r)
    end
    rd(8'h08);
    `CHK("rx word reg", 32'h36, d)
  endtask : t_status
  task automatic t_idle;
    @(posedge clk);
    idle_cmd <= 1'b1;
    infer_idle <= 1'b1;
    repeat (3) @(posedge clk);
    #1 `CHK("tx idle", 1'b1, tx_idle_r)
    `CHK("inferred idle", 1'b1, idle_ind_r)
    @(posedge clk);
    idle_cmd <= 1'b0;
    infer_idle <= 1'b0;
    repeat (3) @(posedge clk);
    #1 `CHK("tx active", 1'b0, tx_idle_r)
    `CHK("no inference", 1'b0, idle_ind_r)
    wr(8'h00, 32'h0);
    sig_detect <= 1'b1;
    repeat (5) @(posedge clk);
    #1 `CHK("signal seen", 1'b0, idle_ind_r)
    @(posedge clk);
    sig_detect <= 1'b0;
    repeat (3) @(posedge clk);
    rd(8'h04);
    `CHK("stat idle", 1'b1, d[ppsrv_pkg::STAT_IDLE])
    wr(8'h00, 32'h1);
  endtask : t_idle
  task automatic t_det;
    int k;
    int p;
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      slow <= s[0];
      idle_cmd <= 1'b1;
      ps_cmd <= ppsrv_pkg::PS_P1;
      repeat (12) @(posedge clk);
      det_cmd <= 1'b1;
      det_hit_pin <= 1'b1;
      @(posedge clk);
      det_cmd <= 1'b0;
      repeat (3) @(posedge clk);
      det_done_pin <= 1'b1;
      for (k = 0; k < 20 && phy_done_r !== 1'b1; k++) begin
        @(posedge clk);
        #1;
      end
      `CHK("detect done", 1'b1, phy_done_r)
      `CHK("detected code", ppsrv_pkg::RXST_DETECTED, rx_status_r)
      @(posedge clk);
      det_done_pin <= 1'b0;
      det_hit_pin <= 1'b0;
      #1 `CHK("done pulse end", 1'b0, phy_done_r)
      repeat (2) @(posedge clk);
      #1 `CHK("request dropped", 1'b0, det_loop_req)
      @(posedge clk);
      ps_cmd <= 2'h0;
      idle_cmd <= 1'b0;
      p = 0;
      repeat (12) begin
        @(posedge clk);
        #1 p += int'(phy_done_r === 1'b1);
      end
      `CHK("power ack pulses", 1, p)
    end
  endtask : t_det
  task automatic t_rst;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      rst_v <= 3'(1 << i);
      rx_word_ok <= 1'b1;
      repeat (5) @(posedge clk);
      #1 `CHK("reset out", 3'(1 << i), {tx_pcs_rst_r, rx_pcs_rst_r, rx_pma_rst_r})
      `CHK("valid in reset", i != 1, rx_valid_r)
      @(posedge clk);
      rst_v <= 3'h0;
      hush(5);
      #1 `CHK("reset out off", 3'h0, {tx_pcs_rst_r, rx_pcs_rst_r, rx_pma_rst_r})
    end
    @(posedge clk);
    block_pwrdn <= 1'b1;
    rx_word_ok <= 1'b1;
    repeat (5) @(posedge clk);
    #1 `CHK("power down", 4'hd, {block_off_r, tx_idle_r, rx_valid_r, rx_pcs_rst_r})
    @(posedge clk);
    block_pwrdn <= 1'b0;
    hush(5);
    #1 `CHK("power up", 1'b0, block_off_r)
  endtask : t_rst
  task automatic t_bist;
    wr(8'h00, 32'h15);
    for (int i = 0; i < 255; i++) feed(W'(i));
    hush(3);
    rd(8'h04);
    `CHK("bist early", 2'b00, d[1:0])
    feed(W'(255));
    hush(3);
    rd(8'h04);
    `CHK("bist done", 2'b10, d[1:0])
    wr(8'h00, 32'h15);
    feed(W'(0));
    feed(W'(1));
    feed(W'(7));
    feed(W'(8));
    feed(W'(9));
    hush(3);
    rd(8'h04);
    `CHK("bist error", 2'b11, d[1:0])
  endtask : t_bist
  task automatic t_prbs;
    wr(8'h00, 32'h17);
    for (int i = 0; i < 127; i++) feed(pw());
    hush(3);
    rd(8'h04);
    `CHK("prbs early", 2'b00, d[1:0])
    feed(pw());
    hush(3);
    rd(8'h04);
    `CHK("prbs done", 2'b10, d[1:0])
    // Oldest bit flipped so the next word still predicts cleanly
    feed(pw() ^ W'(1));
    feed(pw());
    hush(0);
    rd(8'h04);
    `CHK("prbs err held", 2'b11, d[1:0])
    feed(pw());
    feed(pw());
    hush(4);
    rd(8'h04);
    `CHK("prbs err clear", 3'b110, d[2:0])
    wr(8'h00, 32'h9);
    rd(8'h04);
    `CHK("cal done off", 1'b0, d[2])
    #1 `CHK("cal stopped", 1'b0, cal_run_r)
    wr(8'h00, 32'h1);
    repeat (20) @(posedge clk);
    #1 `CHK("cal restarted", 1'b1, cal_run_r)
  endtask : t_prbs
  task automatic results;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_status();
    t_idle();
    t_det();
    t_rst();
    t_bist();
    t_prbs();
    results();
  end
  // Tests need about 650 cycles; 50 us leaves a wide margin
  initial begin
    #50000;
    errors++;
    results();
  end
endmodule : tb
`default_nettype wire
